// ### pkg/tdg_pkg.sv
// constants, register map and types for the three-phase deadtime gate control
// assumes a single 40 MHz clock and an AXI4-Lite register port
package tdg_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int DT_STEP_NS = 50;
   localparam int DT_MAX_NS = 12000;
   localparam int DT_STEP_CYC = (DT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DT_MAX_STEPS = DT_MAX_NS / DT_STEP_NS;
   localparam int T_BLANK_NS = 500;
   localparam int BLANK_CYC = (T_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DT_W = 12;
   localparam int BLANK_W = 6;
   // register byte offsets
   localparam logic [7:0] ADDR_DEADTIME = 8'h00;
   localparam logic [7:0] ADDR_CAL = 8'h04;
   localparam logic [7:0] ADDR_MODE = 8'h08;
   localparam logic [7:0] ADDR_SIMUL = 8'h0c;
   localparam logic [7:0] ADDR_FMASK = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   // field positions
   localparam int MODE_FULL = 0;
   localparam int MODE_DESAT = 1;
   localparam int MODE_ZDT = 2;
   localparam int MODE_LOCK = 3;
   localparam int NUM_FAULTS = 4;
   localparam int FAULT_DESAT = 1;
   localparam int FMASK_INT_LSB = 4;
   // reset values
   localparam logic [7:0] DEADTIME_RST = 8'h00;
   localparam logic [3:0] CAL_RST = 4'(DT_STEP_CYC);
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam logic [7:0] FMASK_RST = 8'h0f;
   // key bytes of the simultaneous-conduction unlock sequence
   localparam logic [7:0] SIM_KEY_ARM = 8'h5a;
   localparam logic [7:0] SIM_KEY_COMMIT = 8'ha5;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {SEL_NONE, SEL_HS, SEL_LS} tdg_sel_t;
   typedef enum logic [1:0] {SIM_IDLE, SIM_ARMED, SIM_DONE} tdg_sim_t;
endpackage

// ### rtl/tdg_phase.sv
// one phase: edge-sensitive command decode, deadtime, bootstrap lockout, blanking
// assumes command inputs already synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module tdg_phase
   import tdg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic hs_cmd_n,
   input wire logic ls_cmd,
   input wire logic [DT_W-1:0] dt_cycles,
   input wire logic simul_en,
   input wire logic kill,
   output logic hs_on_q,
   output logic ls_on_q,
   output logic blank_q,
   output logic boot_ok_q
);
   logic hs_req, hs_prev_q, ls_prev_q, hs_rise, ls_rise, hs_d, ls_d;
   tdg_sel_t sel_q, sel_d;
   logic [DT_W-1:0] dt_cnt_q;
   logic [BLANK_W-1:0] blank_cnt_q;

   assign hs_req = ~hs_cmd_n;
   assign hs_rise = hs_req & ~hs_prev_q;
   assign ls_rise = ls_cmd & ~ls_prev_q;

   // last leading edge selects the side; its release deselects
   always_comb begin
      sel_d = sel_q;
      if (ls_rise) begin
         sel_d = SEL_LS;
      end else if (hs_rise) begin
         sel_d = SEL_HS;
      end else if ((sel_q == SEL_HS && !hs_req) || (sel_q == SEL_LS && !ls_cmd)) begin
         sel_d = SEL_NONE;
      end
   end

   // gate requests; outside simultaneous mode the complementary side must be off and deadtime spent
   always_comb begin
      if (simul_en) begin
         hs_d = enable & hs_req & boot_ok_q & ~kill;
         ls_d = enable & ls_cmd & ~kill;
      end else begin
         hs_d = enable & ~kill & (sel_d == SEL_HS) & (dt_cnt_q == '0) & ~ls_on_q
            & boot_ok_q;
         ls_d = enable & ~kill & (sel_d == SEL_LS) & (dt_cnt_q == '0) & ~hs_on_q;
      end
   end

   // input history and selection
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hs_prev_q <= 1'b0;
         ls_prev_q <= 1'b0;
         sel_q <= SEL_NONE;
      end else begin
         hs_prev_q <= hs_req;
         ls_prev_q <= ls_cmd;
         sel_q <= sel_d;
      end
   end

   // gate outputs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hs_on_q <= 1'b0;
         ls_on_q <= 1'b0;
      end else begin
         hs_on_q <= hs_d;
         ls_on_q <= ls_d;
      end
   end

   // deadtime counter loads at every turn-off, zero means no delay
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dt_cnt_q <= '0;
      end else if ((hs_on_q & ~hs_d) | (ls_on_q & ~ls_d)) begin
         dt_cnt_q <= dt_cycles;
      end else if (dt_cnt_q != '0) begin
         dt_cnt_q <= dt_cnt_q - 1'b1;
      end
   end

   // bootstrap charged once the low side has been on since enable
   always_ff @(posedge clk) begin
      if (!rst_n || !enable) begin
         boot_ok_q <= 1'b0;
      end else if (ls_on_q) begin
         boot_ok_q <= 1'b1;
      end
   end

   // current-limit blanking after any input change, bypassed in simultaneous mode
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         blank_cnt_q <= '0;
         blank_q <= 1'b0;
      end else if (simul_en) begin
         blank_cnt_q <= '0;
         blank_q <= 1'b0;
      end else if ((hs_req ^ hs_prev_q) | (ls_cmd ^ ls_prev_q)) begin
         blank_cnt_q <= BLANK_W'(BLANK_CYC);
         blank_q <= 1'b1;
      end else begin
         if (blank_cnt_q != '0) begin
            blank_cnt_q <= blank_cnt_q - 1'b1;
         end
         blank_q <= (blank_cnt_q > BLANK_W'(1));
      end
   end
endmodule
`default_nettype wire

// ### rtl/tdg_gate_ctrl.sv
// top of the three-phase deadtime gate control with its axi4-lite registers
// assumes commands, faults and enable synchronous to REF_CLK (40 MHz)
//
// Summary of operation
// - deadtime programmable 0 to 12 us in 50 ns steps over the register port
// - host writes a calibration of cycles per step; device applies it
// - high and low side of a phase never on together unless enabled
// - simultaneous mode bypasses the current-limit blanking time
// - simultaneous enable needs an arm write then a commit write
// - simultaneous enable or disable accepted once per reset only
// - modes full conduction, desat handling, zero deadtime can be locked
// - masks choose which faults are reported and which raise the interrupt
// - status register readable by the host at any time
// - leading command edge turns complementary off and arms chosen side
// - deadtime starts at turn-off; complementary held off until it ends
// - turn-on after deadtime expiry acts at once
// - high side refused until low side has been on once after enable
// - low-side current limit blanked after each input change
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module tdg_gate_ctrl
   import tdg_pkg::*;
#(
   parameter int NUM_PHASES = 3
)(
   input wire logic REF_CLK,
   input wire logic RST_N,
   // axi4-lite slave
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // phase commands and gate requests
   input wire logic GATE_ENABLE,
   input wire logic [NUM_PHASES-1:0] PHASE_HIGH_SIDE_COMMAND_N,
   input wire logic [NUM_PHASES-1:0] PHASE_LOW_SIDE_COMMAND,
   input wire logic [NUM_FAULTS-1:0] FAULT_IN,
   output logic [NUM_PHASES-1:0] HS_GATE_ON,
   output logic [NUM_PHASES-1:0] LS_GATE_ON,
   output logic [NUM_PHASES-1:0] LS_ILIM_BLANK,
   output logic FULL_CONDUCTION_MODE,
   output logic FAULT_INT
);
   // refuse phase counts the status word cannot hold
   if (NUM_PHASES < 1 || NUM_PHASES > 8) begin : g_chk
      $error("NUM_PHASES must be 1 to 8");
   end

   // write channel state
   logic aw_got_q, w_got_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_do;
   logic [31:0] wmask;
   logic wr_hit;
   // read channel state
   logic rd_do;
   logic [31:0] rd_word;
   logic rd_hit;
   // registers
   logic [7:0] deadtime_q;
   logic [3:0] cal_q;
   logic [3:0] mode_q;
   logic [7:0] fmask_q;
   logic [NUM_FAULTS-1:0] fault_q;
   logic desat_trip_q;
   logic simul_en_q;
   tdg_sim_t sim_q;
   // derived
   logic [7:0] dt_steps;
   logic [DT_W-1:0] dt_cycles;
   logic [NUM_FAULTS-1:0] fault_clr;
   logic [NUM_PHASES-1:0] boot_ok;
   logic kill;

   // byte-lane mask of the pending write
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{w_strb_q[i]}};
      end
   end

   assign wr_do = aw_got_q & w_got_q & ~S_AXI_BVALID;
   assign rd_do = S_AXI_ARREADY & S_AXI_ARVALID;

   // write address channel
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         aw_got_q <= 1'b0;
         S_AXI_AWREADY <= 1'b0;
         aw_addr_q <= '0;
      end else if (S_AXI_AWREADY & S_AXI_AWVALID) begin
         aw_got_q <= 1'b1;
         S_AXI_AWREADY <= 1'b0;
         aw_addr_q <= S_AXI_AWADDR;
      end else if (S_AXI_BVALID & S_AXI_BREADY) begin
         aw_got_q <= 1'b0;
         S_AXI_AWREADY <= 1'b1;
      end else if (!aw_got_q) begin
         S_AXI_AWREADY <= 1'b1;
      end
   end

   // write data channel
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         w_got_q <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (S_AXI_WREADY & S_AXI_WVALID) begin
         w_got_q <= 1'b1;
         S_AXI_WREADY <= 1'b0;
         w_data_q <= S_AXI_WDATA;
         w_strb_q <= S_AXI_WSTRB;
      end else if (S_AXI_BVALID & S_AXI_BREADY) begin
         w_got_q <= 1'b0;
         S_AXI_WREADY <= 1'b1;
      end else if (!w_got_q) begin
         S_AXI_WREADY <= 1'b1;
      end
   end

   // address decode for writes
   always_comb begin
      unique case (aw_addr_q)
         ADDR_DEADTIME, ADDR_CAL, ADDR_MODE, ADDR_SIMUL, ADDR_FMASK, ADDR_STATUS: begin
            wr_hit = 1'b1;
         end
         default: begin
            wr_hit = 1'b0;
         end
      endcase
   end

   // write response, slverr for unmapped addresses
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= RESP_OKAY;
      end else if (wr_do) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // deadtime steps and calibration cycles per step
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         deadtime_q <= DEADTIME_RST;
         cal_q <= CAL_RST;
      end else if (wr_do && aw_addr_q == ADDR_DEADTIME) begin
         deadtime_q <= (deadtime_q & ~wmask[7:0]) | (w_data_q[7:0] & wmask[7:0]);
      end else if (wr_do && aw_addr_q == ADDR_CAL) begin
         cal_q <= (cal_q & ~wmask[3:0]) | (w_data_q[3:0] & wmask[3:0]);
      end
   end

   // clamp to 12 us and scale by the calibration
   assign dt_steps = (deadtime_q > 8'(DT_MAX_STEPS)) ? 8'(DT_MAX_STEPS) : deadtime_q;
   assign dt_cycles = mode_q[MODE_ZDT] ? '0 : DT_W'(dt_steps) * DT_W'(cal_q);

   // operating modes, frozen once the lock bit is set
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         mode_q <= MODE_RST;
      end else if (wr_do && aw_addr_q == ADDR_MODE && !mode_q[MODE_LOCK]) begin
         mode_q <= (mode_q & ~wmask[3:0]) | (w_data_q[3:0] & wmask[3:0]);
      end
   end

   // simultaneous conduction: arm then commit, once per reset
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         sim_q <= SIM_IDLE;
         simul_en_q <= 1'b0;
      end else if (wr_do && aw_addr_q == ADDR_SIMUL && w_strb_q[1:0] == 2'h3) begin
         unique case (sim_q)
            SIM_IDLE: begin
               if (w_data_q[15:8] == SIM_KEY_ARM) begin
                  sim_q <= SIM_ARMED;
               end
            end
            SIM_ARMED: begin
               if (w_data_q[15:8] == SIM_KEY_COMMIT) begin
                  sim_q <= SIM_DONE;
                  simul_en_q <= w_data_q[0];
               end else begin
                  sim_q <= SIM_IDLE;
               end
            end
            SIM_DONE: begin
               sim_q <= SIM_DONE;
            end
         endcase
      end else if (wr_do && sim_q == SIM_ARMED) begin
         sim_q <= SIM_IDLE;
      end
   end

   // fault masks: low nibble reports, high nibble raises the interrupt
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         fmask_q <= FMASK_RST;
      end else if (wr_do && aw_addr_q == ADDR_FMASK) begin
         fmask_q <= (fmask_q & ~wmask[7:0]) | (w_data_q[7:0] & wmask[7:0]);
      end
   end

   assign fault_clr = (wr_do && aw_addr_q == ADDR_STATUS) ?
      (w_data_q[NUM_FAULTS-1:0] & wmask[NUM_FAULTS-1:0]) : '0;

   // sticky reported faults, a new fault wins over a clear
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         fault_q <= '0;
      end else begin
         fault_q <= (fault_q & ~fault_clr) | (FAULT_IN & fmask_q[NUM_FAULTS-1:0]);
      end
   end

   // desaturation shutdown when that handling mode is on
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         desat_trip_q <= 1'b0;
      end else if (FAULT_IN[FAULT_DESAT] && mode_q[MODE_DESAT]) begin
         desat_trip_q <= 1'b1;
      end else if (fault_clr[FAULT_DESAT]) begin
         desat_trip_q <= 1'b0;
      end
   end

   assign kill = desat_trip_q;

   // interrupt level and mode pin
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         FAULT_INT <= 1'b0;
         FULL_CONDUCTION_MODE <= 1'b0;
      end else begin
         FAULT_INT <= |(fault_q & fmask_q[FMASK_INT_LSB +: NUM_FAULTS]);
         FULL_CONDUCTION_MODE <= mode_q[MODE_FULL];
      end
   end

   // read mux
   always_comb begin
      rd_hit = 1'b1;
      unique case (S_AXI_ARADDR)
         ADDR_DEADTIME: rd_word = 32'(deadtime_q);
         ADDR_CAL: rd_word = 32'(cal_q);
         ADDR_MODE: rd_word = 32'(mode_q);
         ADDR_SIMUL: rd_word = 32'({sim_q, simul_en_q});
         ADDR_FMASK: rd_word = 32'(fmask_q);
         ADDR_STATUS: rd_word = 32'({LS_GATE_ON, HS_GATE_ON, boot_ok, desat_trip_q,
            mode_q[MODE_LOCK], sim_q == SIM_DONE, simul_en_q, fault_q});
         default: begin
            rd_word = '0;
            rd_hit = 1'b0;
         end
      endcase
   end

   // read address and data channels
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= '0;
         S_AXI_RRESP <= RESP_OKAY;
      end else if (rd_do) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_word;
         S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID & S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end else if (!S_AXI_RVALID) begin
         S_AXI_ARREADY <= 1'b1;
      end
   end

   // one gate controller per phase
   for (genvar p = 0; p < NUM_PHASES; p++) begin : g_phase
      tdg_phase u_phase (
         .clk(REF_CLK),
         .rst_n(RST_N),
         .enable(GATE_ENABLE),
         .hs_cmd_n(PHASE_HIGH_SIDE_COMMAND_N[p]),
         .ls_cmd(PHASE_LOW_SIDE_COMMAND[p]),
         .dt_cycles(dt_cycles),
         .simul_en(simul_en_q),
         .kill(kill),
         .hs_on_q(HS_GATE_ON[p]),
         .ls_on_q(LS_GATE_ON[p]),
         .blank_q(LS_ILIM_BLANK[p]),
         .boot_ok_q(boot_ok[p])
      );
   end
endmodule
`default_nettype wire

// ### tb/tdg_host_model.sv
// host side of the phase command pins, with the pin pull levels
// assumes the bench gives on-requests per phase and a drive flag
`timescale 1ns/100ps
`default_nettype none
module tdg_host_model #(
   parameter int NUM_PHASES = 3
)(
   input wire logic drive,
   input wire logic [NUM_PHASES-1:0] hs_on,
   input wire logic [NUM_PHASES-1:0] ls_on,
   output logic [NUM_PHASES-1:0] hs_cmd_n,
   output logic [NUM_PHASES-1:0] ls_cmd
);
   // undriven pins rest inactive: high side pulled up, low side pulled down
   assign hs_cmd_n = drive ? ~hs_on : '1;
   assign ls_cmd = drive ? ls_on : '0;
endmodule
`default_nettype wire

// ### tb/tdg_gate_ctrl_props.sv
// port checker for the gate control top: axi handshakes and phase 0 gating
// assumes one clock domain; bound onto every instance of the top
`timescale 1ns/100ps
`default_nettype none
module tdg_gate_ctrl_props #(
   parameter int NUM_PHASES = 3
)(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic GATE_ENABLE,
   input wire logic [NUM_PHASES-1:0] PHASE_HIGH_SIDE_COMMAND_N,
   input wire logic [NUM_PHASES-1:0] PHASE_LOW_SIDE_COMMAND,
   input wire logic [NUM_PHASES-1:0] HS_GATE_ON,
   input wire logic [NUM_PHASES-1:0] LS_GATE_ON,
   input wire logic [NUM_PHASES-1:0] LS_ILIM_BLANK
);
   logic boot_seen_q;
   default clocking dcb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);
   // remembers a low-side turn-on of phase 0 since enable
   always_ff @(posedge REF_CLK) begin
      if (!RST_N || !GATE_ENABLE) begin
         boot_seen_q <= 1'b0;
      end else if (LS_GATE_ON[0]) begin
         boot_seen_q <= 1'b1;
      end
   end
   // steps of the bus transfers and of a command change
   sequence s_wr_take;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence s_rd_take;
      S_AXI_ARVALID && S_AXI_ARREADY;
   endsequence
   sequence s_in_change;
      $changed(PHASE_HIGH_SIDE_COMMAND_N[0]) || $changed(PHASE_LOW_SIDE_COMMAND[0]);
   endsequence
   a_no_overlap: assert property ((HS_GATE_ON & LS_GATE_ON) == '0)
      else $error("both gates of a phase on");
   a_hs_edge_off: assert property ($fell(PHASE_HIGH_SIDE_COMMAND_N[0]) |=> !LS_GATE_ON[0])
      else $error("low side not dropped on high-side edge");
   a_ls_edge_off: assert property ($rose(PHASE_LOW_SIDE_COMMAND[0]) |=> !HS_GATE_ON[0])
      else $error("high side not dropped on low-side edge");
   a_boot_first: assert property ($rose(HS_GATE_ON[0]) |-> boot_seen_q)
      else $error("high side on before any low side");
   a_blank_run: assert property (s_in_change |=> LS_ILIM_BLANK[0] [*8])
      else $error("blanking missing after input change");
   a_wr_answer: assert property (s_wr_take |-> ##2 S_AXI_BVALID)
      else $error("write response late");
   a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped");
   a_rd_answer: assert property (s_rd_take |=> S_AXI_RVALID && !S_AXI_ARREADY)
      else $error("read answer late");
   a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
endmodule
bind tdg_gate_ctrl tdg_gate_ctrl_props #(.NUM_PHASES(NUM_PHASES)) u_props (
   .REF_CLK(REF_CLK),
   .RST_N(RST_N),
   .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RDATA(S_AXI_RDATA),
   .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY),
   .GATE_ENABLE(GATE_ENABLE),
   .PHASE_HIGH_SIDE_COMMAND_N(PHASE_HIGH_SIDE_COMMAND_N),
   .PHASE_LOW_SIDE_COMMAND(PHASE_LOW_SIDE_COMMAND),
   .HS_GATE_ON(HS_GATE_ON),
   .LS_GATE_ON(LS_GATE_ON),
   .LS_ILIM_BLANK(LS_ILIM_BLANK)
);
`default_nettype wire

// ### tb/tdg_gate_ctrl_tb.sv
// self-checking bench: axi4-lite register tasks and phase 0 command sequences
// assumes tdg_pkg constants and the host pin model beside the top
`timescale 1ns/100ps
`default_nettype none
module tdg_gate_ctrl_tb
   import tdg_pkg::*;
;
   localparam int DT_SET = 3;
   localparam int CAL_SET = 2;
   localparam int D_CYC = DT_SET * CAL_SET;
   localparam logic [31:0] ARM_W = {16'h0, SIM_KEY_ARM, 8'h00};
   localparam logic [31:0] COMMIT_W = {16'h0, SIM_KEY_COMMIT, 8'h00};
   logic clk, rst_n = 1'b0, gate_en = 1'b0, drive = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, fcm, fint;
   logic [1:0] bresp, rresp;
   logic [2:0] hs_on = 3'h0, ls_on = 3'h0, hs_n, ls_cmd, hs_g, ls_g, blank;
   logic [3:0] fault = 4'h0;
   int failures = 0, n_checks = 0;
   // design and the host pin model
   tdg_gate_ctrl uut (
      .REF_CLK(clk),
      .RST_N(rst_n),
      .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf),
      .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready),
      .GATE_ENABLE(gate_en),
      .PHASE_HIGH_SIDE_COMMAND_N(hs_n),
      .PHASE_LOW_SIDE_COMMAND(ls_cmd),
      .FAULT_IN(fault),
      .HS_GATE_ON(hs_g),
      .LS_GATE_ON(ls_g),
      .LS_ILIM_BLANK(blank),
      .FULL_CONDUCTION_MODE(fcm),
      .FAULT_INT(fint)
   );
   tdg_host_model host (
      .drive(drive),
      .hs_on(hs_on),
      .ls_on(ls_on),
      .hs_cmd_n(hs_n),
      .ls_cmd(ls_cmd)
   );
   // clock at 40 MHz
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t ns: %s", $time, what);
      end
   endtask
   task automatic conclude();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // one write: address and data offered together, response awaited
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk({bvalid, bresp}, {1'b1, er}, "write response");
   endtask
   // one read, compared under a mask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                     input logic [31:0] m = '1);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk({rvalid, rresp, rdata & m}, {1'b1, er, e}, "read");
   endtask
   // counts edges until the phase 0 gate turns on
   task automatic wait_on(input bit hs, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (!(hs ? hs_g[0] : ls_g[0]) && n < 600);
   endtask
   // watchdog well beyond the length of the tests
   initial begin
      #(20000 * 25);
      failures++;
      conclude();
   end
   // main sequence
   initial begin
      int n;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      gate_en <= 1'b1;
      rd(ADDR_DEADTIME, 32'(DEADTIME_RST), RESP_OKAY);
      rd(ADDR_CAL, 32'(CAL_RST), RESP_OKAY);
      rd(ADDR_MODE, 32'(MODE_RST), RESP_OKAY);
      rd(ADDR_FMASK, 32'(FMASK_RST), RESP_OKAY);
      rd(8'h20, 32'h0, RESP_SLVERR);
      wr(8'h20, 32'h1, RESP_SLVERR);
      $display("test registers done");
      wr(ADDR_CAL, 32'(CAL_SET), RESP_OKAY);
      wr(ADDR_DEADTIME, 32'(DT_SET), RESP_OKAY);
      @(posedge clk);
      hs_on[0] <= 1'b1;
      repeat (12) @(posedge clk);
      #1;
      chk(40'(hs_g[0]), 40'h0, "high side before low side");
      @(posedge clk);
      hs_on[0] <= 1'b0;
      repeat (20) @(posedge clk);
      ls_on[0] <= 1'b1; // low side first to charge the bootstrap
      wait_on(1'b0, n);
      chk(40'(n), 40'd1, "low side from idle");
      chk(40'(blank[0]), 40'h1, "blanking after change");
      @(posedge clk);
      hs_on[0] <= 1'b1;
      @(posedge clk);
      #1;
      chk(40'(ls_g[0]), 40'h0, "low side dropped");
      wait_on(1'b1, n);
      chk(40'(n + 1), 40'(D_CYC + 2), "deadtime to high side");
      @(posedge clk);
      hs_on[0] <= 1'b0;
      ls_on[0] <= 1'b0;
      repeat (D_CYC + 10) @(posedge clk);
      ls_on[0] <= 1'b1;
      wait_on(1'b0, n);
      chk(40'(n), 40'd1, "turn-on after expiry");
      wr(ADDR_DEADTIME, 32'h0, RESP_OKAY);
      @(posedge clk);
      hs_on[0] <= 1'b1;
      wait_on(1'b1, n);
      chk(40'(n), 40'd2, "zero deadtime");
      @(posedge clk);
      hs_on[0] <= 1'b0;
      ls_on[0] <= 1'b0;
      $display("test deadtime done");
      wr(ADDR_DEADTIME, 32'(DT_SET), RESP_OKAY);
      wr(ADDR_MODE, 32'h1, RESP_OKAY);
      repeat (2) @(posedge clk);
      #1;
      chk(40'(fcm), 40'h1, "full conduction pin");
      wr(ADDR_MODE, 32'he, RESP_OKAY);
      wr(ADDR_MODE, 32'h1, RESP_OKAY);
      rd(ADDR_MODE, 32'he, RESP_OKAY);
      chk(40'(fcm), 40'h0, "mode locked");
      ls_on[0] <= 1'b1;
      wait_on(1'b0, n);
      @(posedge clk);
      hs_on[0] <= 1'b1;
      wait_on(1'b1, n);
      chk(40'(n), 40'd2, "zero deadtime mode");
      @(posedge clk);
      hs_on[0] <= 1'b0;
      ls_on[0] <= 1'b0;
      $display("test modes done");
      wr(ADDR_SIMUL, ARM_W, RESP_OKAY);
      rd(ADDR_SIMUL, 32'h2, RESP_OKAY);
      wr(ADDR_SIMUL, 32'h0, RESP_OKAY);
      rd(ADDR_SIMUL, 32'h0, RESP_OKAY);
      wr(ADDR_SIMUL, ARM_W, RESP_OKAY);
      wr(ADDR_SIMUL, COMMIT_W, RESP_OKAY);
      wr(ADDR_SIMUL, ARM_W, RESP_OKAY);
      wr(ADDR_SIMUL, COMMIT_W | 32'h1, RESP_OKAY);
      rd(ADDR_SIMUL, 32'h4, RESP_OKAY);
      $display("test simultaneous done");
      @(posedge clk);
      fault[0] <= 1'b1;
      @(posedge clk);
      fault[0] <= 1'b0;
      rd(ADDR_STATUS, 32'h61, RESP_OKAY, 32'hff);
      chk(40'(fint), 40'h0, "interrupt masked");
      wr(ADDR_FMASK, 32'h1f, RESP_OKAY);
      repeat (2) @(posedge clk);
      #1;
      chk(40'(fint), 40'h1, "interrupt raised");
      wr(ADDR_STATUS, 32'h1, RESP_OKAY);
      rd(ADDR_STATUS, 32'h60, RESP_OKAY, 32'hff);
      chk(40'(fint), 40'h0, "interrupt cleared");
      wr(ADDR_FMASK, 32'h0e, RESP_OKAY);
      @(posedge clk);
      fault[0] <= 1'b1;
      @(posedge clk);
      fault[0] <= 1'b0;
      rd(ADDR_STATUS, 32'h60, RESP_OKAY, 32'hff);
      // desat with shutdown mode on kills the gates until cleared
      @(posedge clk);
      fault[1] <= 1'b1;
      @(posedge clk);
      fault[1] <= 1'b0;
      rd(ADDR_STATUS, 32'he2, RESP_OKAY, 32'hff);
      ls_on[0] <= 1'b1;
      wait_on(1'b0, n);
      chk(40'(n), 40'd600, "desat shutdown");
      wr(ADDR_STATUS, 32'h2, RESP_OKAY);
      @(posedge clk);
      drive <= 1'b0;
      #1;
      chk(40'(ls_g[0]), 40'h1, "desat cleared");
      // released pins fall back to their pull levels
      repeat (2) @(posedge clk);
      #1;
      chk(40'({hs_g[0], ls_g[0]}), 40'h0, "released pins idle");
      $display("test faults done");
      conclude();
   end
endmodule
`default_nettype wire
